// ==== rtl/serial_mode_map.svh ====
// constants for the serial mode control block
// Operation
// - serial port accepts and latches commands in every mode, shutdown included
// - 8-bit command register; bits 2..0 pick the mode, 7..3 ignored
// - code 000 shutdown: reference, ADCs, DACs off, ADC bus high impedance
// - code 001 idle: reference and clocks on, converters off, ADC bus released
// - code 010 receive: reference and ADCs on, bus driven, DACs off
// - code 011 transmit: reference and DACs on, ADCs off, bus released
// - code 100 transceive: reference, ADCs and DACs all on, bus driven
// - code 101 standby: only ADC reference on, converters off, bus released
// - ADC bus re-enabled shows the last converted word first
// - DAC data registers are cleared on leaving shutdown
// - from shutdown: 40 us to transceive or transmit, 10 us to receive
// - from idle: 10 us, or 40 us when converter clock was static
// - select low opens a write; data shifts only while select is low
// - bits arrive MSB first, one per rising serial-clock edge
// - when select rises after eight or more bits, a code 000 to 101 in the shift register is copied into the mode latch
// - serial clock idle level may be either; device does not depend on it
// - wake and recovery intervals start when select rises latching the command
// - switching among receive, transmit, transceive needs 10 us recovery
// - shutdown or standby into transceive needs 40 us recovery
`ifndef SERIAL_MODE_MAP_SVH
`define SERIAL_MODE_MAP_SVH
`define MODE_CMD_WIDTH 8
`define MODE_FIELD_LSB 0
`define MODE_FIELD_MSB 2
`define MODE_RESET_CODE 3'h0
`define CLOCK_MHZ 20
`define WAKE_SHORT_US 10
`define WAKE_LONG_US 40
`define WAKE_SHORT_CYCLES (`WAKE_SHORT_US * `CLOCK_MHZ)
`define WAKE_LONG_CYCLES (`WAKE_LONG_US * `CLOCK_MHZ)
`define CMD_GAP_NS 80
`endif

// ==== rtl/serial_mode_pkg.sv ====
// types for the serial mode control block
package serial_mode_pkg;
   typedef enum logic [2:0] {
      mode_shutdown = 3'h0,
      mode_idle = 3'h1,
      mode_receive = 3'h2,
      mode_transmit = 3'h3,
      mode_transceive = 3'h4,
      mode_standby = 3'h5
   } op_mode_t;
   typedef struct packed {
      logic ref_en;
      logic clk_dist_en;
      logic adc_en;
      logic dac_en;
      logic adc_bus_drive;
   } power_ctl_t;
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
   } serial_pins_t;
endpackage : serial_mode_pkg

// ==== rtl/serial_shifter.sv ====
// serial command shifter sampled on the system clock
`timescale 1ns/1ps
module serial_shifter #(
   parameter int WIDTH = 8
) (
   input wire logic clock,
   input wire logic rst_sync_n,
   input wire serial_mode_pkg::serial_pins_t pins,
   output logic [WIDTH-1:0] cmd,
   output logic cmd_valid
);
   import serial_mode_pkg::*;
   // the six-bit edge counter and the shift slice cannot serve other widths
   if (WIDTH < 2 || WIDTH > 32) begin : g_width_bad
      $error("serial_shifter width unsupported");
   end
   // ==========================================================
   // pin synchronisers
   serial_pins_t meta;
   serial_pins_t pin_s;
   logic sclk_prev;
   logic cs_prev;
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         meta <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};
         pin_s <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};
      end else begin
         meta <= pins;
         pin_s <= meta;
      end
   end
   // previous sclk resets low and edges count only while select is low, so idle polarity never matters
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sclk_prev <= 1'b0;
         cs_prev <= 1'b1;
      end else begin
         sclk_prev <= pin_s.sclk;
         cs_prev <= pin_s.cs_n;
      end
   end
   wire sclk_rise = pin_s.sclk && !sclk_prev && !pin_s.cs_n;
   wire cs_fall = !pin_s.cs_n && cs_prev;
   wire cs_rise = pin_s.cs_n && !cs_prev;
   // ==========================================================
   // shift and count
   logic [WIDTH-1:0] shreg;
   logic [5:0] count;
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         shreg <= '0;
         count <= '0;
      end else if (cs_fall) begin
         count <= '0;
      end else if (sclk_rise) begin
         shreg <= {shreg[WIDTH-2:0], pin_s.din};
         if (count < 6'(WIDTH)) begin
            count <= count + 6'h01;
         end
      end
   end
   // command is copied out on every select rise; cmd_valid pulses only if a full word arrived
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cmd <= '0;
         cmd_valid <= 1'b0;
      end else begin
         cmd_valid <= cs_rise && (count >= 6'(WIDTH));
         if (cs_rise) begin
            cmd <= shreg;
         end
      end
   end
endmodule : serial_shifter

// ==== rtl/serial_mode_control.sv ====
// serial mode control: command port, mode decode, wake timing
`timescale 1ns/1ps
`include "serial_mode_map.svh"
module serial_mode_control #(
   parameter int WAKE_SHORT = `WAKE_SHORT_CYCLES,
   parameter int WAKE_LONG = `WAKE_LONG_CYCLES,
   parameter int DAC_WIDTH = 10,
   parameter int ADC_WIDTH = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire serial_mode_pkg::serial_pins_t serial_pins,
   input wire logic conv_clk_static,
   input wire logic [ADC_WIDTH-1:0] adc_word,
   input wire logic adc_word_valid,
   input wire logic [DAC_WIDTH-1:0] dac_word,
   input wire logic dac_word_valid,
   output serial_mode_pkg::op_mode_t mode,
   output serial_mode_pkg::power_ctl_t power,
   output logic [ADC_WIDTH-1:0] adc_output_bus,
   output logic adc_output_bus_oe_n,
   output logic [DAC_WIDTH-1:0] dac_data,
   output logic ready
);
   import serial_mode_pkg::*;
   // the wake counter is sixteen bits wide
   if (WAKE_SHORT < 1 || WAKE_LONG < WAKE_SHORT || WAKE_LONG > 65535) begin : g_wake_bad
      $error("wake counts unsupported");
   end
   // ==========================================================
   // reset release
   logic rst_meta_n;
   logic rst_sync_n;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end
   // ==========================================================
   // command capture, alive in every mode
   logic [`MODE_CMD_WIDTH-1:0] cmd;
   logic cmd_valid;
   serial_shifter #(.WIDTH(`MODE_CMD_WIDTH)) u_shifter (
      .clock(clock),
      .rst_sync_n(rst_sync_n),
      .pins(serial_pins),
      .cmd(cmd),
      .cmd_valid(cmd_valid)
   );
   // static-clock hint is a pin from outside, so synchronise it
   logic static_meta;
   logic static_s;
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         static_meta <= 1'b0;
         static_s <= 1'b0;
      end else begin
         static_meta <= conv_clk_static;
         static_s <= static_meta;
      end
   end
   // ==========================================================
   // mode decode
   function automatic logic code_ok(input logic [2:0] c);
      code_ok = (c <= 3'h5);
   endfunction : code_ok
   function automatic power_ctl_t decode(input op_mode_t m);
      power_ctl_t p;
      p = '0;
      case (m)
         mode_shutdown: p = '0;
         mode_idle: begin
            p.ref_en = 1'b1;
            p.clk_dist_en = 1'b1;
         end
         mode_receive: begin
            p.ref_en = 1'b1;
            p.clk_dist_en = 1'b1;
            p.adc_en = 1'b1;
            p.adc_bus_drive = 1'b1;
         end
         mode_transmit: begin
            p.ref_en = 1'b1;
            p.clk_dist_en = 1'b1;
            p.dac_en = 1'b1;
         end
         mode_transceive: begin
            p.ref_en = 1'b1;
            p.clk_dist_en = 1'b1;
            p.adc_en = 1'b1;
            p.dac_en = 1'b1;
            p.adc_bus_drive = 1'b1;
         end
         mode_standby: p.ref_en = 1'b1;
         default: p = '0;
      endcase
      return p;
   endfunction : decode
   function automatic logic is_active(input op_mode_t m);
      is_active = (m == mode_receive) || (m == mode_transmit) || (m == mode_transceive);
   endfunction : is_active
   // upper five bits are don't-care; undefined codes 110/111 leave the mode alone
   wire [2:0] new_code = cmd[`MODE_FIELD_MSB:`MODE_FIELD_LSB];
   wire take = cmd_valid && code_ok(new_code);
   op_mode_t new_mode;
   assign new_mode = op_mode_t'(new_code);
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mode <= op_mode_t'(`MODE_RESET_CODE);
      end else if (take) begin
         mode <= new_mode;
      end
   end
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         power <= '0;
      end else if (take) begin
         power <= decode(new_mode);
      end
   end
   // ==========================================================
   // wake and recovery timer
   function automatic logic [15:0] wake_len(input op_mode_t from, input op_mode_t to, input logic stat);
      wake_len = 16'h0000;
      if (is_active(to) && from != to) begin
         case (from)
            mode_shutdown: wake_len = (to == mode_receive) ? 16'(WAKE_SHORT) : 16'(WAKE_LONG);
            mode_idle: wake_len = stat ? 16'(WAKE_LONG) : 16'(WAKE_SHORT);
            mode_standby: wake_len = (to == mode_transceive) ? 16'(WAKE_LONG) : 16'(WAKE_SHORT);
            mode_receive, mode_transmit, mode_transceive: wake_len = 16'(WAKE_SHORT);
            default: wake_len = 16'(WAKE_LONG);
         endcase
      end
   endfunction : wake_len
   logic [15:0] wake_count;
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wake_count <= 16'h0000;
      end else if (take) begin
         wake_count <= wake_len(mode, new_mode, static_s);
      end else if (wake_count != 16'h0000) begin
         wake_count <= wake_count - 16'h0001;
      end
   end
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ready <= 1'b0;
      end else begin
         ready <= is_active(mode) && wake_count == 16'h0000 && !take;
      end
   end
   // ==========================================================
   // ADC output bus: hold last converted word through tri-state
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         adc_output_bus <= '0;
      end else if (adc_word_valid && power.adc_en) begin
         adc_output_bus <= adc_word;
      end
   end
   // enable low while driving
   assign adc_output_bus_oe_n = !power.adc_bus_drive;
   // ==========================================================
   // DAC data register, wiped when shutdown ends
   // host must keep dac_word at solid levels when DACs are off
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dac_data <= '0;
      end else if (take && mode == mode_shutdown && new_mode != mode_shutdown) begin
         dac_data <= '0;
      end else if (dac_word_valid && power.dac_en) begin
         dac_data <= dac_word;
      end
   end
endmodule : serial_mode_control

// ==== bench/serial_mode_control_checker.sv ====
// port assertions for the serial mode control block
`timescale 1ns/1ps
module serial_mode_control_checker
   import serial_mode_pkg::*;
#(
   parameter int WAKE_SHORT = 4,
   parameter int WAKE_LONG = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire serial_mode_pkg::serial_pins_t serial_pins,
   input wire logic conv_clk_static,
   input wire logic [7:0] adc_word,
   input wire logic adc_word_valid,
   input wire serial_mode_pkg::op_mode_t mode,
   input wire serial_mode_pkg::power_ctl_t power,
   input wire logic [7:0] adc_output_bus,
   input wire logic adc_output_bus_oe_n,
   input wire logic [9:0] dac_data,
   input wire logic ready
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   localparam int SHORT_HI = WAKE_SHORT + 4;
   localparam int LONG_LO = WAKE_LONG - 2;
   function automatic logic act(op_mode_t m);
      return m inside {mode_receive, mode_transmit, mode_transceive};
   endfunction : act
   // slow cases: shutdown into transmit or transceive, both converters (transceive) from standby, stopped clock in idle
   function automatic logic slow(op_mode_t p, op_mode_t m, logic s);
      return (p == mode_shutdown && m != mode_receive) || (p == mode_standby && m == mode_transceive)
         || (p == mode_idle && s);
   endfunction : slow
   // =====
   // assertions
   sequence short_wait;
      ##1 (!ready)[*2] ##[1:SHORT_HI] ready;
   endsequence
   sequence long_wait;
      ##1 !ready ##LONG_LO !ready ##[1:6] ready;
   endsequence
   ref_power_a: assert property (power.ref_en == (mode != mode_shutdown))
      else $error("reference enable wrong");
   clk_dist_a: assert property (power.clk_dist_en == (mode inside {mode_idle, mode_receive, mode_transmit,
      mode_transceive})) else $error("clock distribution enable wrong");
   adc_bus_a: assert property (power.adc_en == !adc_output_bus_oe_n)
      else $error("adc enable and bus drive differ");
   adc_mode_a: assert property (power.adc_en == (mode inside {mode_receive, mode_transceive}))
      else $error("adc enable wrong");
   dac_mode_a: assert property (power.dac_en == (mode inside {mode_transmit, mode_transceive}))
      else $error("dac enable wrong");
   latch_gap_a: assert property ($changed(mode) |-> $past(serial_pins.cs_n, 3))
      else $error("mode changed while selected");
   dac_clear_a: assert property ($past(mode) == mode_shutdown && mode != mode_shutdown |-> dac_data == 0)
      else $error("dac word kept across shutdown");
   short_wake_a: assert property ($changed(mode) && act(mode) && !slow($past(mode), mode, conv_clk_static)
      |-> short_wait) else $error("short wake timing wrong");
   long_wake_a: assert property ($changed(mode) && act(mode) && slow($past(mode), mode, conv_clk_static)
      |-> long_wait) else $error("long wake timing wrong");
   bus_hold_a: assert property (adc_output_bus_oe_n |=> $stable(adc_output_bus))
      else $error("adc word lost while released");
   adc_take_a: assert property (adc_word_valid && !adc_output_bus_oe_n |=> adc_output_bus == $past(adc_word))
      else $error("adc word not taken");
endmodule : serial_mode_control_checker
bind serial_mode_control serial_mode_control_checker #(.WAKE_SHORT(WAKE_SHORT), .WAKE_LONG(WAKE_LONG))
   serial_mode_control_checker_i (.*);

// ==== bench/serial_host_model.sv ====
// host model driving the three-wire command port
`timescale 1ns/1ps
module serial_host_model
   import serial_mode_pkg::*;
(
   input wire logic clock,
   output serial_mode_pkg::serial_pins_t pins
);
   localparam int HALF = 4; // half of a 400 ns link clock
   initial pins = 3'h2;
   task automatic send(input logic [7:0] value, input int nbits, input logic idle);
      pins.sclk <= idle;
      repeat (HALF) @(posedge clock);
      pins.cs_n <= 1'h0;
      for (int i = 0; i < nbits; i++) begin
         pins.sclk <= 1'h0;
         pins.din <= value[7 - i];
         repeat (HALF) @(posedge clock);
         pins.sclk <= 1'h1;
         repeat (HALF) @(posedge clock);
      end
      pins.cs_n <= 1'h1;
      pins.din <= ~pins.din; // a released line keeps no stale bit
      repeat (HALF) @(posedge clock);
      pins.sclk <= idle;
   endtask : send
endmodule : serial_host_model

// ==== bench/serial_mode_control_tb_top.sv ====
// self-checking bench for the serial mode control block
`timescale 1ns/1ps
module serial_mode_control_tb_top;
   import serial_mode_pkg::*;
   localparam int WAKE_SHORT = 4;
   localparam int WAKE_LONG = 16;
   logic clock, rst_n, conv_clk_static, adc_word_valid, dac_word_valid, adc_output_bus_oe_n, ready;
   logic [7:0] adc_word, adc_output_bus;
   logic [9:0] dac_word, dac_data;
   serial_pins_t serial_pins;
   op_mode_t mode;
   power_ctl_t power;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   serial_host_model serial_host_model_i (.clock(clock), .pins(serial_pins));
   serial_mode_control #(.WAKE_SHORT(WAKE_SHORT), .WAKE_LONG(WAKE_LONG)) serial_mode_control_i (
      .clock(clock), .rst_n(rst_n), .serial_pins(serial_pins), .conv_clk_static(conv_clk_static),
      .adc_word(adc_word), .adc_word_valid(adc_word_valid), .dac_word(dac_word), .dac_word_valid(dac_word_valid),
      .mode(mode), .power(power), .adc_output_bus(adc_output_bus), .adc_output_bus_oe_n(adc_output_bus_oe_n),
      .dac_data(dac_data), .ready(ready));
   initial begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   // =====
   // shared tasks
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic write(input logic [7:0] value, input int nbits = 8, input logic idle = 1'h0);
      serial_host_model_i.send(value, nbits, idle);
      repeat (6) @(posedge clock);
   endtask : write
   task automatic pulse(input logic [7:0] a, input logic [9:0] d);
      adc_word <= a;
      dac_word <= d;
      {adc_word_valid, dac_word_valid} <= 2'h3;
      @(posedge clock);
      {adc_word_valid, dac_word_valid} <= 2'h0;
      repeat (2) @(posedge clock);
   endtask : pulse
   // =====
   // scenarios
   task automatic t_decode();
      logic [2:0] c;
      for (int i = 0; i < 6; i++) begin
         c = 3'(5 - i);
         write({5'h1F, c}, 8, i[0]);
         check(mode, c);
         check({power.ref_en, power.adc_en, power.dac_en}, {c != 0, c == 2 || c == 4, c == 3 || c == 4});
      end
   endtask : t_decode
   task automatic t_refuse();
      write(8'h02);
      write(8'h1C, 5);
      check(mode, mode_receive);
      write(8'h06);
      write(8'h07);
      check(mode, mode_receive);
   endtask : t_refuse
   task automatic t_bus();
      pulse(8'hA5, 10'h111);
      check(adc_output_bus, 8'hA5);
      write(8'h03);
      pulse(8'h3C, 10'h2A5);
      check(dac_data, 10'h2A5);
      check(adc_output_bus_oe_n, 1'h1);
      write(8'h02);
      check(adc_output_bus, 8'hA5);
      write(8'h00);
      write(8'h01);
      check(dac_data, 10'h000);
   endtask : t_bus
   task automatic t_wake(input logic [2:0] from, input logic [2:0] to, input logic stat, input logic slow);
      int n;
      conv_clk_static <= stat;
      write({5'h00, from});
      repeat (WAKE_LONG + 8) @(posedge clock);
      serial_host_model_i.send({5'h00, to}, 8, 1'h1);
      repeat (3) @(posedge clock);
      n = 0;
      while (ready !== 1'h1 && n < 100) begin
         @(posedge clock);
         n++;
      end
      check(ready, 1'h1);
      check(n > WAKE_SHORT + 4, slow);
   endtask : t_wake
   task automatic t_reset();
      write(8'h04);
      rst_n <= 1'h0;
      repeat (2) @(posedge clock);
      check({mode, ready, adc_output_bus_oe_n}, 5'h01);
      rst_n <= 1'h1;
      repeat (4) @(posedge clock);
      write(8'h02);
      check(mode, mode_receive);
   endtask : t_reset
   initial begin
      {rst_n, conv_clk_static, adc_word_valid, dac_word_valid} = 4'h0;
      adc_word = 8'h00;
      dac_word = 10'h000;
      repeat (3) @(posedge clock);
      rst_n <= 1'h1;
      repeat (4) @(posedge clock);
      t_decode();
      t_refuse();
      t_bus();
      t_wake(3'h0, 3'h4, 1'h0, 1'h1);
      t_wake(3'h0, 3'h2, 1'h0, 1'h0);
      t_wake(3'h0, 3'h3, 1'h0, 1'h1);
      t_wake(3'h1, 3'h2, 1'h0, 1'h0);
      t_wake(3'h1, 3'h2, 1'h1, 1'h1);
      t_wake(3'h5, 3'h4, 1'h0, 1'h1);
      t_wake(3'h2, 3'h3, 1'h0, 1'h0);
      t_wake(3'h3, 3'h4, 1'h0, 1'h0);
      t_reset();
      print_verdict();
   end
endmodule : serial_mode_control_tb_top
